// ===== design/wic_consts.svh
// Register offsets, field positions, reset values and counts of the interval counter.
`ifndef WIC_CONSTS_SVH
`define WIC_CONSTS_SVH

// Byte offsets of the registers on the bus.
`define WIC_OFF_CTRL     8'h00
`define WIC_OFF_FRAC     8'h04
`define WIC_OFF_SEC      8'h08
`define WIC_OFF_MIN      8'h0C
`define WIC_OFF_HOUR     8'h10
`define WIC_OFF_INTERVAL_COMPARE_VALUE   8'h14
`define WIC_OFF_STAT     8'h18
`define WIC_OFF_MASK     8'h1C
`define WIC_OFF_ICNT     8'h20

// Field positions of the control register.
`define WIC_CTRL_TIME_CLOCK_ENABLE    0
`define WIC_CTRL_INTERVAL_COUNT_ENABLE    1
`define WIC_CTRL_FLAG    2
`define WIC_CTRL_SINGLE  3
`define WIC_CTRL_TB_LO   4
`define WIC_CTRL_TB_HI   5
`define WIC_CTRL_TFH     6

// Bit positions of the status and mask registers.
`define WIC_ST_MATCH     0
`define WIC_ST_SECOND    1

// Reset values.
`define WIC_RST_BYTE     8'h00
`define WIC_RST_EVT      2'h0

// Counting limits of the time chain.
`define WIC_FRAC_LAST    8'h7F
`define WIC_SEC_LAST     8'h3B
`define WIC_MIN_LAST     8'h3B
`define WIC_HOUR_LAST24  8'h17
`define WIC_HOUR_LAST256 8'hFF

// Crystal edges per fraction tick: 32768 Hz down to 128 Hz.
`define WIC_PRESC_LAST   8'hFF

// Vector address presented on wake-up.
`define WIC_WAKE_VECTOR  16'h0053

`endif

// ===== design/wic_interval_counter.sv
// Wake-up interval counter: Wishbone registers, time chain and interval match.
//
// How it works
// [R01] Intervals from 1/128 second to 255 hours.
// [R02] Chain runs from crystal, also in power-down.
// [R03] Software allows slow register accesses to finish.
// [R04] Selected overflow steps the 8-bit interval counter.
// [R05] Match sets flag, interrupts when enabled.
// [R06] Match wakes power-down, vector 0053H.
// [R07] Time registers preloadable with current time.
// [R08] Six registers, control register among them; the block maps nine, adding status, mask and interval count.
// [R09] Timebase field selects fraction, second, minute, hour.
// [R10] Single mode stops; otherwise counter reloads.
// [R11] Clock enable low restores last written time.
// [R12] Fraction counts 0-127, seconds and minutes 0-59.
// [R13] Crystal and core domains cross without corruption.
`timescale 1ns/1ps
`include "wic_consts.svh"
module wic_interval_counter
  import wic_pkg::*;
(
  // Core clock, synchronous reset and clock enable.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Classic Wishbone slave port; registers sit in the low byte of each word.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Crystal pin, asynchronous to the core clock.
  input  wire logic        xtal_i,
  // Power-down state of the core and the interrupt and wake-up answers.
  input  wire logic        pwr_down_i,
  output logic             irq_o,
  output logic             wake_o,
  output logic      [15:0] wake_vector_o
);

  // Register map, one byte in the low lane of each 32-bit word:
  //   00 control: b6 24-hour wrap, b5:4 timebase, b3 single interval,
  //      b2 match flag, b1 interval enable, b0 time clock enable.
  //   04 fraction, 08 seconds, 0C minutes, 10 hours.
  //   14 interval value; the match comes when the stepped count equals it.
  //   18 status, write one to clear: b0 interval match, b1 second rollover.
  //   1C interrupt mask of the same layout.
  //   20 interval count, read only.
  // Unmapped offsets answer like any other and read as zero.

  // Bus state.
  logic        ack_ff;
  logic [31:0] dat_ff;

  // Control fields.
  logic          time_clock_enable_ff;
  logic          interval_count_enable_ff;
  logic          single_ff;
  logic          tfh_ff;
  wic_tbsel_type tbsel_ff;

  // Interval value, interval counter, events and mask.
  logic [7:0] interval_compare_value_ff;
  logic [7:0] icnt_ff;
  logic [1:0] stat_ff;
  logic [1:0] mask_ff;

  // Last software-written time values.
  logic [7:0] shadow_ff [4];

  // Crystal prescaler.
  logic [7:0] presc_ff;

  // Wake-up outputs.
  logic        wake_ff;
  logic [15:0] vec_ff;

  // Next values.
  logic [7:0] nxt_presc;
  logic [7:0] nxt_icnt;
  logic [1:0] nxt_stat;
  logic       nxt_interval_count_enable;

  // Chain connections.
  logic       xtal_rise;
  logic [7:0] time_cnt [4];
  logic [3:0] time_ovf;
  logic [3:0] time_load;
  logic [7:0] time_val [4];

  // The crystal is sampled as a slow pin rather than used as a clock, so the
  // whole block lives in one domain and no register value ever crosses clocks.
  // [R13] Crystal pin synchronised into core clock.
  wic_sync u_xtal_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .pin_i  (xtal_i),
    .rise_o (xtal_rise)
  );

  // The answer never stalls: every access completes one cycle after it is taken.
  // Masking with ack stops a held strobe from being taken a second time.
  // Request decode; a request is taken once, on the edge that raises ack.
  wire       req    = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire       wr     = req & wb_we_i & wb_sel_i[0];
  wire [7:0] adr    = {wb_adr_i[7:2], 2'b00};
  wire [7:0] wbyte  = wb_dat_i[7:0];

  // Address bits 1:0 are ignored, so any byte address inside a word selects it.
  // Exactly one hit is high for a mapped offset and none for the others.
  // Address hits.
  wire hit_ctrl   = adr == `WIC_OFF_CTRL;
  wire hit_frac   = adr == `WIC_OFF_FRAC;
  wire hit_sec    = adr == `WIC_OFF_SEC;
  wire hit_min    = adr == `WIC_OFF_MIN;
  wire hit_hour   = adr == `WIC_OFF_HOUR;
  wire hit_interval_compare_value = adr == `WIC_OFF_INTERVAL_COMPARE_VALUE;
  wire hit_stat   = adr == `WIC_OFF_STAT;
  wire hit_mask   = adr == `WIC_OFF_MASK;
  wire hit_icnt   = adr == `WIC_OFF_ICNT;

  // Only byte lane 0 carries register data, so a write without it is dropped.
  // The strobes last one cycle, on the edge that takes the request.
  // Write strobes.
  wire wr_ctrl   = wr & hit_ctrl;
  wire wr_interval_compare_value = wr & hit_interval_compare_value;
  wire wr_stat   = wr & hit_stat;
  wire wr_mask   = wr & hit_mask;
  wire [3:0] wr_time = {4{wr}} & {hit_hour, hit_min, hit_sec, hit_frac};

  // Bit 7 is not implemented and reads as zero; bit 2 shows the match event.
  // Control register image as software reads it.
  wire [7:0] ctrl_rd = {1'b0, tfh_ff, tbsel_ff, single_ff,
                        stat_ff[`WIC_ST_MATCH], interval_count_enable_ff, time_clock_enable_ff};

  // The time registers read the live count, or the restore copy while stopped.
  // [R08] Read selection; unmapped offsets read zero.
  wire [7:0] rd_byte = hit_ctrl   ? ctrl_rd :
                       hit_frac   ? time_cnt[0] :
                       hit_sec    ? time_cnt[1] :
                       hit_min    ? time_cnt[2] :
                       hit_hour   ? time_cnt[3] :
                       hit_interval_compare_value ? interval_compare_value_ff :
                       hit_stat   ? {6'h00, stat_ff} :
                       hit_mask   ? {6'h00, mask_ff} :
                       hit_icnt   ? icnt_ff : `WIC_RST_BYTE;

  // With the clock enable low, ack and data freeze along with all other state,
  // so a request pending at that moment is answered once the enable returns.
  // Bus handshake: ack one cycle after the request, data held with it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else if (ce_i) begin
      ack_ff <= req;
      dat_ff <= req ? {24'h000000, rd_byte} : dat_ff;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // The interval enable is kept apart, since a timeout may also clear it.
  // Control fields written by software.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      time_clock_enable_ff   <= 1'b0;
      single_ff <= 1'b0;
      tfh_ff    <= 1'b0;
      tbsel_ff  <= WIC_TB_FRAC;
    end else if (ce_i && wr_ctrl) begin
      time_clock_enable_ff   <= wbyte[`WIC_CTRL_TIME_CLOCK_ENABLE];
      single_ff <= wbyte[`WIC_CTRL_SINGLE];
      tfh_ff    <= wbyte[`WIC_CTRL_TFH];
      tbsel_ff  <= wic_tbsel_type'(wbyte[`WIC_CTRL_TB_HI:`WIC_CTRL_TB_LO]);
    end
  end

  // Both may be rewritten at any time; a new interval value takes effect at the next step.
  // Interval value and interrupt mask.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interval_compare_value_ff <= `WIC_RST_BYTE;
      mask_ff   <= `WIC_RST_EVT;
    end else if (ce_i) begin
      interval_compare_value_ff <= wr_interval_compare_value ? wbyte : interval_compare_value_ff;
      mask_ff   <= wr_mask ? wbyte[1:0] : mask_ff;
    end
  end

  // The restore copy is what a stopped clock shows, so software that preloads
  // the current time and then starts the clock can always restart from it.
  // [R07] Each time write updates the restore copy.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_shadow
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          shadow_ff[g] <= `WIC_RST_BYTE;
        end else if (ce_i && wr_time[g]) begin
          shadow_ff[g] <= wbyte;
        end
      end
      // [R11] Disabled clock holds last written time.
      assign time_load[g] = wr_time[g] | ~time_clock_enable_ff;
      assign time_val[g]  = wr_time[g] ? wbyte : shadow_ff[g];
    end
  endgenerate

  // The prescaler is held at zero while the time clock is off, so the first
  // fraction tick comes a full 256 crystal edges after software starts it.
  // [R02] Divide crystal edges down to the 128 Hz tick.
  wire tick128 = xtal_rise & (presc_ff == `WIC_PRESC_LAST);
  assign nxt_presc = ~time_clock_enable_ff ? `WIC_RST_BYTE :
                     xtal_rise ? presc_ff + 8'h01 : presc_ff;

  // The prescaler wraps by itself, so the tick recurs every 256 edges.
  // Prescaler register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_ff <= `WIC_RST_BYTE;
    end else if (ce_i) begin
      presc_ff <= nxt_presc;
    end
  end

  // The chain is loaded from the restore copy on every cycle while stopped,
  // and loaded directly by a time write while it runs.
  // [R12] Fraction, second, minute and hour chain.
  wic_time_chain u_chain (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .tick_i     (tick128),
    .run_i      (time_clock_enable_ff),
    .tfh_i      (tfh_ff),
    .load_i     (time_load),
    .load_val_i (time_val),
    .cnt_o      (time_cnt),
    .ovf_o      (time_ovf)
  );

  // Each source fires once per unit of the chosen timebase: the fraction tick
  // itself, or the overflow of the register one place below the chosen unit.
  // [R01] Steps of 1/128 second, seconds, minutes or hours.
  wire       tick_step = tick128 & time_clock_enable_ff;
  wire       sec_step  = time_ovf[0];
  wire       min_step  = time_ovf[1];
  wire       hour_step = time_ovf[2];
  wire [3:0] step_src  = {hour_step, min_step, sec_step, tick_step};

  // [R09] Overflow source per timebase field.
  wire sel_ovf = step_src[tbsel_ff];

  // [R04] Step interval counter on selected overflow.
  wire       int_step = sel_ovf & interval_count_enable_ff;
  wire [7:0] int_inc  = icnt_ff + 8'h01;
  // [R05] Match of stepped count with interval value.
  wire       int_hit  = int_step & (int_inc == interval_compare_value_ff);

  // An interval value of zero matches only after the count wraps, that is
  // after 256 steps, which gives the longest interval of the block.
  // [R10] Reload on timeout; cleared while disabled.
  assign nxt_icnt = ~interval_count_enable_ff ? `WIC_RST_BYTE :
                    int_hit  ? `WIC_RST_BYTE :
                    int_step ? int_inc : icnt_ff;

  // Software that rewrites the enable in the timeout cycle keeps what it wrote.
  // [R10] Single mode timeout drops the enable; a write wins.
  assign nxt_interval_count_enable = wr_ctrl ? wbyte[`WIC_CTRL_INTERVAL_COUNT_ENABLE] :
                    (int_hit & single_ff) ? 1'b0 : interval_count_enable_ff;

  // The count restarts from zero whenever the enable is set again.
  // Interval counter and its enable.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      icnt_ff <= `WIC_RST_BYTE;
      interval_count_enable_ff <= 1'b0;
    end else if (ce_i) begin
      icnt_ff <= nxt_icnt;
      interval_count_enable_ff <= nxt_interval_count_enable;
    end
  end

  // Status bit 0 is the interval match, also seen as control bit 2; bit 1 marks
  // each roll-over of the fraction register, once per second.
  // Event clears: ones to status, or zero to the control flag bit.
  wire [1:0] stat_clr = ({2{wr_stat}} & wbyte[1:0]) |
                        {1'b0, wr_ctrl & ~wbyte[`WIC_CTRL_FLAG]};
  wire [1:0] stat_set = {time_ovf[0], int_hit};

  // [R05] Sticky events; a set in the clear cycle wins.
  assign nxt_stat = stat_set | (stat_ff & ~stat_clr);

  // An event that lands in a clear cycle is kept, so none is ever lost.
  // Status register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_ff <= `WIC_RST_EVT;
    end else if (ce_i) begin
      stat_ff <= nxt_stat;
    end
  end

  // The interrupt is a level: it stays high until software clears the event
  // or masks it, so a match seen during a long handler is never lost.
  // [R05] Interrupt while an unmasked event is pending.
  assign irq_o = |(stat_ff & mask_ff);

  // Only the interval match may wake the core, and only while it is unmasked.
  // [R06] Wake a powered-down core at the interval vector.
  wire wake_now = pwr_down_i & stat_ff[`WIC_ST_MATCH] & mask_ff[`WIC_ST_MATCH];

  // The wake level and its vector are registered so that the core sees both
  // change together, one cycle after the match flag is set.
  // Wake level and vector registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_ff <= 1'b0;
      vec_ff  <= 16'h0000;
    end else if (ce_i) begin
      wake_ff <= wake_now;
      vec_ff  <= wake_now ? `WIC_WAKE_VECTOR : 16'h0000;
    end
  end

  assign wake_o        = wake_ff;
  assign wake_vector_o = vec_ff;

endmodule : wic_interval_counter

// ===== design/wic_pkg.sv
// Types shared by the interval counter modules.
package wic_pkg;

  // Overflow source that steps the interval counter.
  typedef enum logic [1:0] {
    WIC_TB_FRAC = 2'b00,
    WIC_TB_SEC  = 2'b01,
    WIC_TB_MIN  = 2'b10,
    WIC_TB_HOUR = 2'b11
  } wic_tbsel_type;

endpackage : wic_pkg

// ===== design/wic_sync.sv
// Three-stage synchroniser with agreement filter for the crystal pin.
`timescale 1ns/1ps
module wic_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic pin_i,
  output logic      rise_o
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;

  // A new level counts only once stages two and three agree on it.
  wire agree = (s2_ff == s3_ff) && (s3_ff != lvl_ff);

  // Shift the pin through three stages and keep the accepted level.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff  <= 1'b0;
      s2_ff  <= 1'b0;
      s3_ff  <= 1'b0;
      lvl_ff <= 1'b0;
    end else if (ce_i) begin
      s1_ff  <= pin_i;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= agree ? s3_ff : lvl_ff;
    end
  end

  // One pulse per accepted rising edge.
  assign rise_o = ce_i & agree & s3_ff;

endmodule : wic_sync

// ===== design/wic_time_chain.sv
// Fraction, second, minute and hour counters with overflow carries.
`timescale 1ns/1ps
`include "wic_consts.svh"
module wic_time_chain (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       tick_i,
  input  wire logic       run_i,
  input  wire logic       tfh_i,
  input  wire logic [3:0] load_i,
  input  wire logic [7:0] load_val_i [4],
  output logic      [7:0] cnt_o [4],
  output logic      [3:0] ovf_o
);

  logic [7:0] last [4];
  logic [4:0] carry;

  // Roll-over points; the hour counter wraps at 23 or 255.
  assign last[0] = `WIC_FRAC_LAST;
  assign last[1] = `WIC_SEC_LAST;
  assign last[2] = `WIC_MIN_LAST;
  assign last[3] = tfh_i ? `WIC_HOUR_LAST24 : `WIC_HOUR_LAST256;
  // [R02] Chain stepped by crystal tick.
  assign carry[0] = tick_i & run_i;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_stage
      logic [7:0] cnt_ff;
      logic [7:0] nxt_cnt;
      // [R12] Count to limit, then carry.
      assign carry[g+1] = carry[g] & (cnt_ff >= last[g]);
      assign nxt_cnt    = load_i[g]     ? load_val_i[g] :
                          carry[g+1]    ? `WIC_RST_BYTE :
                          carry[g]      ? cnt_ff + 8'h01 : cnt_ff;
      // One counter of the chain.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt_ff <= `WIC_RST_BYTE;
        end else if (ce_i) begin
          cnt_ff <= nxt_cnt;
        end
      end
      assign cnt_o[g] = cnt_ff;
      assign ovf_o[g] = carry[g+1] & ~load_i[g];
    end
  endgenerate

endmodule : wic_time_chain

// ===== tb/wic_interval_counter_assertions.sv
// Port-level checks of the interval counter's bus answer, interrupt and wake-up.
`timescale 1ns/1ps
module wic_interval_counter_assertions (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_ack_o,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        pwr_down_i,
  input  wire logic        irq_o,
  input  wire logic        wake_o,
  input  wire logic [15:0] wake_vector_o
);
  // All checks share the core clock and its reset.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_follows_req: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_single_pulse: assert property (
    wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack held too long");
  chk_ack_has_cause: assert property (
    wb_ack_o |-> $past(wb_stb_i)) else $error("ack without strobe");
  chk_rdata_upper_zero: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("read data upper bits set");
  chk_vector_on_wake: assert property (
    wake_o |-> wake_vector_o == 16'h0053) else $error("wrong wake vector");
  chk_vector_idle_zero: assert property (
    !wake_o |-> wake_vector_o == 16'h0000) else $error("vector without wake");
  chk_wake_needs_pd: assert property (
    wake_o |-> $past(pwr_down_i) && $past(irq_o)) else $error("wake without cause");
  chk_reset_quiet: assert property (
    $past(rst_i) |-> !irq_o && !wake_o) else $error("outputs active after reset");
endmodule : wic_interval_counter_assertions

bind wic_interval_counter wic_interval_counter_assertions u_chk (
  .clk_i         (clk_i),
  .rst_i         (rst_i),
  .ce_i          (ce_i),
  .wb_cyc_i      (wb_cyc_i),
  .wb_stb_i      (wb_stb_i),
  .wb_ack_o      (wb_ack_o),
  .wb_dat_o      (wb_dat_o),
  .pwr_down_i    (pwr_down_i),
  .irq_o         (irq_o),
  .wake_o        (wake_o),
  .wake_vector_o (wake_vector_o)
);

// ===== tb/wic_interval_counter_tb.sv
// Self-checking bench for the wake-up interval counter.
`timescale 1ns/1ps
module wic_interval_counter_tb;
  logic        clk_i      = 1'b0;
  logic        rst_i      = 1'b1;
  logic        ce_i       = 1'b1;
  logic        wb_cyc_i   = 1'b0;
  logic        wb_stb_i   = 1'b0;
  logic        wb_we_i    = 1'b0;
  logic [7:0]  wb_adr_i   = 8'h00;
  logic [31:0] wb_dat_i   = 32'h0;
  logic        pwr_down_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic [15:0] wake_vector_o;
  logic        wb_ack_o, irq_o, wake_o, xtal;
  logic [7:0]  rd;
  int          mismatches = 0;
  int          compares   = 0;
  int          cycles     = 0;

  // Core clock of 4 ns.
  always #2 clk_i = ~clk_i;

  wic_xtal_model u_xtal (.clk_i(clk_i), .run_i(!rst_i), .xtal_o(xtal));

  wic_interval_counter dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .xtal_i(xtal), .pwr_down_i(pwr_down_i),
    .irq_o(irq_o), .wake_o(wake_o), .wake_vector_o(wake_vector_o));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, dat};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : xfer

  task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
    xfer(1'b0, adr, 8'h00);
    check({8'h00, rd}, {8'h00, exp});
  endtask : rd_chk

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      $display("[FAIL] t=%0t irq wait expired got=%h exp=%h", $time, irq_o, 1'b1);
    end
  endtask : wait_irq

  task automatic t_reset;
    logic [7:0] offs [7];
    offs = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18, 8'h20, 8'h30};
    foreach (offs[k]) begin
      rd_chk(offs[k], 8'h00);
    end
    $display("t_reset done");
  endtask : t_reset

  task automatic t_rollover;
    xfer(1'b1, 8'h04, 8'h7F);
    xfer(1'b1, 8'h08, 8'h3B);
    xfer(1'b1, 8'h0C, 8'h05);
    xfer(1'b1, 8'h00, 8'h01);
    repeat (2300) @(posedge clk_i);
    rd_chk(8'h04, 8'h00);
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h0C, 8'h06);
    xfer(1'b1, 8'h00, 8'h00);
    rd_chk(8'h04, 8'h7F);
    rd_chk(8'h0C, 8'h05);
    $display("t_rollover done");
  endtask : t_rollover

  task automatic t_timebase;
    logic [1:0] tb;
    pwr_down_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      tb = 2'(i);
      xfer(1'b1, 8'h00, 8'h00);
      xfer(1'b1, 8'h04, (i > 0) ? 8'h7F : 8'h00);
      xfer(1'b1, 8'h08, (i > 1) ? 8'h3B : 8'h00);
      xfer(1'b1, 8'h0C, (i > 2) ? 8'h3B : 8'h00);
      xfer(1'b1, 8'h10, 8'h00);
      xfer(1'b1, 8'h14, 8'h01);
      xfer(1'b1, 8'h1C, 8'h01);
      xfer(1'b1, 8'h00, {2'b00, tb, 4'hB});
      wait_irq();
      check(16'(irq_o), 16'h0001);
      rd_chk(8'h00, {2'b00, tb, 4'hD});
      check(16'(wake_o), 16'h0001);
      check(wake_vector_o, 16'h0053);
      xfer(1'b1, 8'h18, 8'h03);
      check(16'(irq_o), 16'h0000);
    end
    $display("t_timebase done");
  endtask : t_timebase

  task automatic t_reload;
    pwr_down_i <= 1'b0;
    xfer(1'b1, 8'h00, 8'h00);
    xfer(1'b1, 8'h14, 8'h01);
    xfer(1'b1, 8'h04, 8'h00);
    xfer(1'b1, 8'h1C, 8'h00);
    xfer(1'b1, 8'h00, 8'h03);
    repeat (2300) @(posedge clk_i);
    check(16'(irq_o), 16'h0000);
    rd_chk(8'h18, 8'h01);
    xfer(1'b1, 8'h1C, 8'h01);
    check(16'(irq_o), 16'h0001);
    xfer(1'b1, 8'h18, 8'h01);
    wait_irq();
    rd_chk(8'h00, 8'h07);
    check(16'(wake_o), 16'h0000);
    $display("t_reload done");
  endtask : t_reload

  // Clock enable low freezes the prescaler and the time chain.
  task automatic t_ce;
    xfer(1'b1, 8'h00, 8'h00);
    check(16'(irq_o), 16'h0000);
    xfer(1'b1, 8'h04, 8'h00);
    xfer(1'b1, 8'h00, 8'h01);
    ce_i <= 1'b0;
    repeat (3000) @(posedge clk_i);
    ce_i <= 1'b1;
    rd_chk(8'h04, 8'h00);
    repeat (2300) @(posedge clk_i);
    rd_chk(8'h04, 8'h01);
    $display("t_ce done");
  endtask : t_ce

  task automatic report_and_stop;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Cuts a hang short well above the expected run of about 20000 cycles.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // Main sequence.
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_rollover();
    t_timebase();
    t_reload();
    t_ce();
    report_and_stop();
  end
endmodule : wic_interval_counter_tb

// ===== tb/wic_xtal_model.sv
// Crystal source model that drives the slow pin of the interval counter.
`timescale 1ns/1ps
module wic_xtal_model (
  input  wire logic clk_i,
  input  wire logic run_i,
  output logic      xtal_o
);
  logic [1:0] div_ff;

  // Crystal domain source.
  // Toggles every four core cycles so each level outlasts the synchroniser.
  always_ff @(posedge clk_i) begin
    if (run_i) begin
      div_ff <= div_ff + 2'h1;
      if (div_ff == 2'h3) begin
        xtal_o <= ~xtal_o;
      end
    end else begin
      div_ff <= 2'h0;
      xtal_o <= 1'b0;
    end
  end
endmodule : wic_xtal_model
